/* File: verilog/dqr_pkg.sv */
// Constants, field layouts and carrier types for the DDR I/Q capture retimer.
// Assumes a single 250 MHz system clock; every pin input is resynchronised inside the block.
package dqr_pkg;

  // Sample word width and clock rate
  localparam int          SAMPLE_W      = 14;
  localparam int          CLOCK_MHZ     = 250;
  localparam int          SYNC_DEPTH    = 3;

  // Search gives up and locks with the default code after this many cycles
  localparam int          SEARCH_CYCLES = 128;
  localparam int          CNT_W         = 8;

  // Retimer phase codes (phase relation of data clock to conversion clock)
  localparam logic [1:0]  CODE_0_90     = 2'h0;   // Selects phase 2
  localparam logic [1:0]  CODE_90_180   = 2'h1;   // Selects phase 3
  localparam logic [1:0]  CODE_180_270  = 2'h2;   // Selects phase 3
  localparam logic [1:0]  CODE_270_360  = 2'h3;   // Selects phase 1

  // Extra retime stages for each selected retimer clock phase
  localparam logic [1:0]  DLY_PHASE1    = 2'h0;
  localparam logic [1:0]  DLY_PHASE2    = 2'h1;
  localparam logic [1:0]  DLY_PHASE3    = 2'h2;

  // Retimer phase control register layout
  localparam int          CTL_Q_LSB     = 6;
  localparam int          CTL_SEARCH    = 4;
  localparam int          CTL_REACQ     = 3;
  localparam int          CTL_FORCE     = 2;
  localparam int          CTL_I_LSB     = 0;

  // Buffer depth
  localparam logic [1:0]  BUF_DEPTH     = 2'h2;

  typedef logic [SAMPLE_W-1:0] dqr_word_t;

  // One I/Q pair as it leaves the block
  typedef struct packed {
    dqr_word_t i;
    dqr_word_t q;
  } dqr_pair_t;

  // Phase search states
  typedef enum logic [2:0] {
    DQR_LOCKED = 3'b001,
    DQR_ARM    = 3'b010,
    DQR_MEAS   = 3'b100
  } dqr_search_t;

  // Entire state of the block
  typedef struct packed {
    logic [SYNC_DEPTH-1:0]           dq_s;
    logic                            dq_f;
    logic [SYNC_DEPTH-1:0]           cv_s;
    logic                            cv_f;
    logic [SYNC_DEPTH-1:0]           sk_s;
    logic                            sk_f;
    logic [SYNC_DEPTH-1:0]           st_s;
    logic                            st_f;
    logic [SYNC_DEPTH-1:0][SAMPLE_W-1:0] bus;
    dqr_word_t                       cap_i;
    dqr_word_t                       cap_q;
    logic                            first_v;
    logic [2:0][SAMPLE_W-1:0]        pipe_i;
    logic [2:0][SAMPLE_W-1:0]        pipe_q;
    logic [2:0]                      pipe_v;
    dqr_word_t                       core_i;
    dqr_word_t                       core_q;
    logic                            core_iv;
    logic                            core_qv;
    dqr_pair_t [1:0]                 mem;
    logic                            wp;
    logic                            rp;
    logic [1:0]                      cnt;
    dqr_search_t                     srch;
    logic                            searching;
    logic [CNT_W-1:0]                tmo;
    logic [CNT_W-1:0]                per;
    logic [CNT_W-1:0]                delta;
    logic                            got_cv;
    logic [1:0]                      code_i;
    logic [1:0]                      code_q;
    logic [1:0]                      i_force;
    logic                            force_en;
    logic                            reacq_prev;
  } dqr_state_t;

endpackage : dqr_pkg

/* File: verilog/dqr_capture_retimer.sv */
// DDR I/Q sample capture, per-channel retiming and a two-entry output buffer.
// Assumes the data and conversion clocks arrive as pins slower than the system clock,
// and that settings bits come from the device register port outside this block.
//
// How it works
// R1: I and Q share one DDR sample bus qualified by the data clock.
// R2: Combined rate up to 250 MSPS at a 125 MHz data clock; the filter here needs two-cycle levels, so at most 62.5 MHz.
// R3: Pair order and capture edge bits are independent, giving four arrangements.
// R4: Bus words latch on the rising or falling data-clock edge per edge select.
// R5: Edge select 1 captures I on rising and Q on falling edge.
// R6: Pair order bit decides whether I or Q of a pair comes first.
// R7: Format bit reads samples as unsigned or two's complement.
// R8: Each channel is retimed into the conversion domain before the core register.
// R9: Pin strap high forces clock input enable on and clock output off.
// R10: In pin mode the other party keeps both clocks in phase.
// R11: Clock input enable low makes the conversion clock the capture clock too.
// R12: Clock output enable drives a data clock derived from the conversion clock.
// R13: Each retimer measures clock phase and picks one of three retimer phases.
// R14: Any working phase may be chosen when several would work.
// R15: Searching flag stays high while the clock relationship is being found.
// R16: A 0-to-1 write of reacquire restarts phase detection in both retimers.
// R17: Two 2-bit readback fields report the I and Q phase codes.
// R18: Code 00 gives phase 2, 01 and 10 phase 3, 11 phase 1.
// R19: Force enable 1 makes the I field override both retimers.
// R20: After reset the search locks within 128 cycles and drops searching.
// R21: Software forces a phase by setting force enable and writing the I field.
// R22: Pin mode with serial clock pin low uses phase 2.
// R23: Pin mode with serial clock pin high uses detection; each rise re-evaluates.
// R24: In-phase clocks with phase 2 forced give fixed I and Q latency.
// R25: Software forces a phase when constant latency matters.
// R26: Field I is writable only while force enable is 1.
// R27: Reacquire during a search restarts it; searching stays high throughout.
`timescale 1ns/1ps
`default_nettype none

module dqr_capture_retimer (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire dqr_pkg::dqr_word_t sample_bus,
  input  wire logic              data_qualify_clock,
  input  wire logic              conversion_clock,
  input  wire logic              reset_pinstrap_pin,
  input  wire logic              serial_clock_pin,
  input  wire logic              pair_order_select,
  input  wire logic              capture_edge_select,
  input  wire logic              twos_format_select,
  input  wire logic              clock_input_enable,
  input  wire logic              clock_output_enable,
  input  wire logic              reg_write,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   pin_strap_mode,
  output logic                   data_clock_out,
  output logic                   data_clock_oe,
  output logic                   sample_ready,
  output logic                   pair_valid,
  input  wire logic              pair_ready,
  output dqr_pkg::dqr_pair_t     pair_data
);

  dqr_pkg::dqr_state_t q;
  dqr_pkg::dqr_state_t n;

  logic                ie_eff;
  logic                oe_eff;
  logic                dq_rise;
  logic                dq_fall;
  logic                cv_rise;
  logic                sk_rise;
  logic                edge_is_i;
  logic                edge_first;
  logic                launch;
  logic                push;
  logic                pop;
  logic                start;
  logic [1:0]          eff_i;
  logic [1:0]          eff_q;
  logic [1:0]          tap_i;
  logic [1:0]          tap_q;
  dqr_pkg::dqr_word_t  bus_fmt;

  // Three-stage filter: a level change counts once stages two and three agree
  function automatic logic sync_filt(input logic [2:0] s, input logic f);
    sync_filt = (s[1] == s[2]) ? s[2] : f;
  endfunction : sync_filt

  // Rising edge of the filtered level, seen one cycle before the filter takes it
  function automatic logic sync_rise(input logic [2:0] s, input logic f);
    sync_rise = (s[1] == s[2]) && s[2] && !f;
  endfunction : sync_rise

  // Offset-binary core word from either input format
  function automatic dqr_pkg::dqr_word_t to_core(input dqr_pkg::dqr_word_t w, input logic twos);
    to_core = twos ? {~w[dqr_pkg::SAMPLE_W-1], w[dqr_pkg::SAMPLE_W-2:0]} : w;
  endfunction : to_core

  // Retime stage count for a phase code; phase 1 needs none, phase 3 the most
  function automatic logic [1:0] phase_delay(input logic [1:0] code);
    case (code)
      dqr_pkg::CODE_0_90:     phase_delay = dqr_pkg::DLY_PHASE2;
      dqr_pkg::CODE_90_180:   phase_delay = dqr_pkg::DLY_PHASE3;
      dqr_pkg::CODE_180_270:  phase_delay = dqr_pkg::DLY_PHASE3;
      default:                phase_delay = dqr_pkg::DLY_PHASE1;
    endcase
  endfunction : phase_delay

  // Quadrant of the conversion edge within one data-clock period
  function automatic logic [1:0] quadrant(input logic [dqr_pkg::CNT_W-1:0] d,
                                          input logic [dqr_pkg::CNT_W-1:0] p);
    logic [dqr_pkg::CNT_W+1:0] d4;
    logic [dqr_pkg::CNT_W+1:0] p1;
    d4 = {d, 2'h0};
    p1 = {2'h0, p};
    if (d4 < p1) begin
      quadrant = dqr_pkg::CODE_0_90;
    end else if (d4 < (p1 << 1)) begin
      quadrant = dqr_pkg::CODE_90_180;
    end else if (d4 < (p1 + (p1 << 1))) begin
      quadrant = dqr_pkg::CODE_180_270;
    end else begin
      quadrant = dqr_pkg::CODE_270_360;
    end
  endfunction : quadrant

  // Next-state logic for the whole block
  always_comb begin
    n = q;
    pin_strap_mode = q.st_f;
    // Pin mode pins the clock enables to their defaults
    ie_eff = q.st_f ? 1'b1 : clock_input_enable;                        // R9
    oe_eff = q.st_f ? 1'b0 : clock_output_enable;                       // R9

    // Resynchronise pins; the capture clock falls back to the conversion clock
    n.dq_s = {q.dq_s[1:0], ie_eff ? data_qualify_clock : conversion_clock}; // R11
    n.cv_s = {q.cv_s[1:0], conversion_clock};
    n.sk_s = {q.sk_s[1:0], serial_clock_pin};
    n.st_s = {q.st_s[1:0], reset_pinstrap_pin};
    n.bus  = {q.bus[1:0], sample_bus};                                  // R1 R2
    n.dq_f = sync_filt(q.dq_s, q.dq_f);
    n.cv_f = sync_filt(q.cv_s, q.cv_f);
    n.sk_f = sync_filt(q.sk_s, q.sk_f);
    n.st_f = sync_filt(q.st_s, q.st_f);
    dq_rise = sync_rise(q.dq_s, q.dq_f);
    dq_fall = (q.dq_s[1] == q.dq_s[2]) && !q.dq_s[2] && q.dq_f;
    cv_rise = sync_rise(q.cv_s, q.cv_f);
    sk_rise = sync_rise(q.sk_s, q.sk_f);

    // Pad capture: edge select names the I edge, pair order the first channel
    bus_fmt    = to_core(q.bus[2], twos_format_select);                 // R7
    edge_is_i  = dq_rise ? capture_edge_select : !capture_edge_select;  // R4 R5
    edge_first = (edge_is_i == pair_order_select);                      // R3 R6
    launch     = 1'b0;
    if (dq_rise || dq_fall) begin
      if (edge_is_i) begin
        n.cap_i = bus_fmt;
      end else begin
        n.cap_q = bus_fmt;
      end
      if (edge_first) begin
        n.first_v = 1'b1;
      end else if (q.first_v) begin
        n.first_v = 1'b0;
        launch    = 1'b1;                                               // R6
      end
    end

    // Retime pipeline: the pair is launched with the second word straight off the bus
    n.pipe_i[0] = edge_is_i ? bus_fmt : q.cap_i;
    n.pipe_q[0] = edge_is_i ? q.cap_q : bus_fmt;
    n.pipe_i[1] = q.pipe_i[0];
    n.pipe_i[2] = q.pipe_i[1];
    n.pipe_q[1] = q.pipe_q[0];
    n.pipe_q[2] = q.pipe_q[1];
    n.pipe_v    = {q.pipe_v[1:0], launch};

    // Effective phase per channel: pin strap, forced, or detected
    if (q.st_f) begin
      eff_i = q.sk_f ? q.code_i : dqr_pkg::CODE_0_90;                   // R22 R23
      eff_q = q.sk_f ? q.code_q : dqr_pkg::CODE_0_90;                   // R22 R23
    end else begin
      eff_i = q.force_en ? q.i_force : q.code_i;                        // R19
      eff_q = q.force_en ? q.i_force : q.code_q;                        // R19
    end
    tap_i = phase_delay(eff_i);                                         // R18 R24
    tap_q = phase_delay(eff_q);                                         // R18 R24

    // Buffer handshake; a full buffer holds the core words instead of dropping them
    pop  = (q.cnt != 2'h0) && pair_ready;
    push = q.core_iv && q.core_qv && (q.cnt != dqr_pkg::BUF_DEPTH);
    if (push) begin
      n.mem[q.wp] = '{i: q.core_i, q: q.core_q};
      n.wp        = ~q.wp;
      n.core_iv   = 1'b0;
      n.core_qv   = 1'b0;
    end
    if (pop) begin
      n.rp = ~q.rp;
    end
    n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};

    // Core registers take each channel at its own retimer tap
    if (q.pipe_v[tap_i] && (!q.core_iv || push)) begin
      n.core_i  = q.pipe_i[tap_i];                                      // R8
      n.core_iv = 1'b1;
    end
    if (q.pipe_v[tap_q] && (!q.core_qv || push)) begin
      n.core_q  = q.pipe_q[tap_q];                                      // R8
      n.core_qv = 1'b1;
    end

    // Register writes; the I field only accepts data while forcing
    start = 1'b0;
    if (reg_write) begin
      n.force_en   = reg_wdata[dqr_pkg::CTL_FORCE];
      n.reacq_prev = reg_wdata[dqr_pkg::CTL_REACQ];
      if (reg_wdata[dqr_pkg::CTL_FORCE]) begin
        n.i_force = reg_wdata[dqr_pkg::CTL_I_LSB +: 2];                 // R26 R21
      end
      if (reg_wdata[dqr_pkg::CTL_REACQ] && !q.reacq_prev && !q.st_f) begin
        start = 1'b1;                                                   // R16
      end
    end
    if (q.st_f && sk_rise) begin
      start = 1'b1;                                                     // R23
    end

    // Phase search shared by both retimers; the first data-clock period that sees a conversion rise sets both codes
    if (q.searching) begin
      n.tmo = q.tmo + 1'b1;
    end
    case (q.srch)
      dqr_pkg::DQR_LOCKED: begin
        n.searching = 1'b0;
      end
      dqr_pkg::DQR_ARM: begin
        if (dq_rise) begin
          n.srch   = dqr_pkg::DQR_MEAS;
          n.per    = '0;
          n.got_cv = 1'b0;
        end
      end
      dqr_pkg::DQR_MEAS: begin
        n.per = q.per + 1'b1;
        if (cv_rise && !q.got_cv) begin
          n.delta  = q.per;
          n.got_cv = 1'b1;
        end
        if (dq_rise) begin
          n.per    = '0;
          n.got_cv = 1'b0;
          if (q.got_cv) begin
            n.code_i    = quadrant(q.delta, q.per + 1'b1);              // R13 R14
            n.code_q    = quadrant(q.delta, q.per + 1'b1);              // R13 R14
            n.srch      = dqr_pkg::DQR_LOCKED;
            n.searching = 1'b0;                                         // R15
          end
        end
      end
      default: begin
        n.srch = dqr_pkg::DQR_ARM;
      end
    endcase
    // Bound on the search: lock with the phase 2 code rather than hang
    if (q.searching && (q.tmo == dqr_pkg::CNT_W'(dqr_pkg::SEARCH_CYCLES - 1))) begin
      n.srch      = dqr_pkg::DQR_LOCKED;                                // R20
      n.searching = 1'b0;
      n.code_i    = dqr_pkg::CODE_0_90;
      n.code_q    = dqr_pkg::CODE_0_90;
    end
    // A start always wins, even mid-search
    if (start) begin
      n.srch      = dqr_pkg::DQR_ARM;                                   // R27
      n.searching = 1'b1;                                               // R15
      n.tmo       = '0;
      n.got_cv    = 1'b0;
    end
  end

  // State register; the search runs straight out of reset
  always_ff @(posedge clock) begin
    if (reset) begin
      q           <= '0;
      q.srch      <= dqr_pkg::DQR_ARM;                                  // R20
      q.searching <= 1'b1;                                              // R15
    end else begin
      q <= n;
    end
  end

  // Outputs; data and readback come straight from flip-flops
  always_comb begin
    reg_rdata = 8'h00;
    reg_rdata[dqr_pkg::CTL_Q_LSB +: 2] = q.code_q;                      // R17
    reg_rdata[dqr_pkg::CTL_SEARCH]     = q.searching;                   // R15
    reg_rdata[dqr_pkg::CTL_REACQ]      = q.reacq_prev;
    reg_rdata[dqr_pkg::CTL_FORCE]      = q.force_en;
    reg_rdata[dqr_pkg::CTL_I_LSB +: 2] = q.force_en ? q.i_force : q.code_i; // R17 R26
  end

  // The forwarded data clock is the filtered conversion clock
  assign data_clock_out = q.cv_f;                                       // R12
  assign data_clock_oe  = oe_eff;                                       // R12
  assign sample_ready   = (q.cnt != dqr_pkg::BUF_DEPTH);
  assign pair_valid     = (q.cnt != 2'h0);
  assign pair_data      = q.mem[q.rp];

  // Checks on the design's own behaviour
  search_bound_a: assert property (@(posedge clock) disable iff (reset) // R20
    q.searching |-> (q.tmo < 8'(dqr_pkg::SEARCH_CYCLES)))
    else $error("phase search ran past its bound");

  reacq_restart_a: assert property (@(posedge clock) disable iff (reset) // R16
    (reg_write && reg_wdata[dqr_pkg::CTL_REACQ] && !q.reacq_prev && !q.st_f)
      |=> (q.searching && (q.tmo == '0) && (q.srch == dqr_pkg::DQR_ARM)))
    else $error("reacquire edge did not restart the search");

  force_override_a: assert property (@(posedge clock) disable iff (reset) // R19
    (!q.st_f && q.force_en) |-> ((eff_i == q.i_force) && (eff_q == q.i_force)))
    else $error("forced phase not applied to both retimers");

  pin_default_a: assert property (@(posedge clock) disable iff (reset) // R22
    (q.st_f && !q.sk_f) |-> ((tap_i == dqr_pkg::DLY_PHASE2) && (tap_q == dqr_pkg::DLY_PHASE2)))
    else $error("pin mode with low serial clock not on phase 2");

  rise_capture_a: assert property (@(posedge clock) disable iff (reset) // R5
    (dq_rise && capture_edge_select) |=> (q.cap_i == $past(bus_fmt)))
    else $error("I word not captured on rising edge");

  fall_capture_a: assert property (@(posedge clock) disable iff (reset) // R4
    (dq_fall && capture_edge_select) |=> (q.cap_q == $past(bus_fmt)))
    else $error("Q word not captured on falling edge");

  strap_clock_a: assert property (@(posedge clock) disable iff (reset) // R9
    q.st_f |-> (!data_clock_oe && ie_eff))
    else $error("pin strap defaults not applied");

  lock_clears_a: assert property (@(posedge clock) disable iff (reset) // R15
    (q.searching && !start && (q.tmo == 8'(dqr_pkg::SEARCH_CYCLES - 1))) |=> !q.searching)
    else $error("searching flag stuck at the search bound");

  readback_i_a: assert property (@(posedge clock) disable iff (reset) // R17
    !q.force_en |-> (reg_rdata[dqr_pkg::CTL_I_LSB +: 2] == q.code_i))
    else $error("I field does not show the detected code");

  buffer_count_a: assert property (@(posedge clock) disable iff (reset)
    (push && !pop) |=> (q.cnt == $past(q.cnt) + 2'h1))
    else $error("buffer count did not follow a push");

  buffer_pop_a: assert property (@(posedge clock) disable iff (reset)
    (pop && !push) |=> (q.cnt == $past(q.cnt) - 2'h1))
    else $error("buffer count did not follow a pop");

  locked_idle_a: assert property (@(posedge clock) disable iff (reset) // R15
    (q.srch == dqr_pkg::DQR_LOCKED) |-> !q.searching)
    else $error("searching flag high while locked");

  pin_retrigger_a: assert property (@(posedge clock) disable iff (reset) // R23
    (q.st_f && sk_rise) |=> (q.searching && (q.srch == dqr_pkg::DQR_ARM)))
    else $error("serial clock rise did not restart the search");

  capture_clock_a: assert property (@(posedge clock) disable iff (reset) // R11
    (!q.st_f && !clock_input_enable) |=> (q.dq_s[0] == $past(conversion_clock)))
    else $error("capture clock not taken from the conversion clock");

  clock_drive_a: assert property (@(posedge clock) disable iff (reset) // R12
    (!q.st_f && clock_output_enable) |-> data_clock_oe)
    else $error("data clock pin not driven when enabled");

endmodule : dqr_capture_retimer

`default_nettype wire

/* File: tb/dqr_src_model.sv */
// Behavioural far-side source: sends one I/Q pair per request over the DDR sample bus.
// Assumes the bench pulses go only while busy is low and feeds the buffer room flag.
`timescale 1ns/1ps
`default_nettype none
module dqr_src_model (
  input  wire logic               clock,
  input  wire logic               go,
  input  wire logic               i_first,
  input  wire logic               i_rise,
  input  wire dqr_pkg::dqr_word_t i_word,
  input  wire dqr_pkg::dqr_word_t q_word,
  input  wire logic               room,
  output logic                    busy,
  output dqr_pkg::dqr_word_t      bus,
  output logic                    dclk,
  output logic                    cclk
);
  dqr_pkg::dqr_word_t w2;

  // Conversion clock tied to the data clock keeps both in phase
  assign cclk = dclk;

  initial begin
    busy = 1'b0;
    bus  = '0;
    dclk = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold

  // One pair: first-channel edge, then the edge that returns the clock to idle.
  // Going to idle first can only make a second-channel edge, which launches nothing.
  always @(posedge clock) begin
    if (go && !busy) begin
      #1 busy = 1'b1;
      dclk = i_first ^ i_rise;
      while (!room) hold(1);
      bus = i_first ? i_word : q_word;
      w2  = i_first ? q_word : i_word;
      hold(4);
      dclk = ~dclk;
      hold(4);
      bus = w2;
      hold(4);
      dclk = ~dclk;
      hold(4);
      // Released bus shows no stale word
      bus = ~bus;
      hold(12);
      busy = 1'b0;
    end else begin
      // Park at this mode's idle level, so a reset never meets a first-channel false edge
      #1 dclk = i_first ^ i_rise;
    end
  end
endmodule : dqr_src_model
`default_nettype wire

/* File: tb/dqr_capture_retimer_tb_top.sv */
// Self-checking bench for the capture retimer: registers, phase search, pin mode, data path.
// Assumes the source model in tb/ and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dqr_capture_retimer_tb_top;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               strap = 1'b0, sck = 1'b0, ord = 1'b1, edg = 1'b1, twos = 1'b0;
  logic               cie = 1'b1, coe = 1'b0, wr = 1'b0, prdy = 1'b0, stall = 1'b0;
  logic               go = 1'b0, psm, doe, dco, srdy, pv, busy, dqc, cvc;
  logic [7:0]         wd = 8'h00, rd;
  logic [31:0]        sd = 32'd51860, rs = 32'd51860;
  dqr_pkg::dqr_word_t bus, iw = '0, qw = '0;
  dqr_pkg::dqr_pair_t pd;
  dqr_pkg::dqr_pair_t exq[$];
  int                 error_cnt = 0, n_checks = 0;
  logic [1:0]         det;

  always #2 clock = ~clock;

  dqr_capture_retimer DUT (.clock(clock), .reset(reset), .sample_bus(bus),
    .data_qualify_clock(dqc), .conversion_clock(cvc), .reset_pinstrap_pin(strap),
    .serial_clock_pin(sck), .pair_order_select(ord), .capture_edge_select(edg),
    .twos_format_select(twos), .clock_input_enable(cie), .clock_output_enable(coe),
    .reg_write(wr), .reg_wdata(wd), .reg_rdata(rd), .pin_strap_mode(psm),
    .data_clock_out(dco), .data_clock_oe(doe), .sample_ready(srdy), .pair_valid(pv),
    .pair_ready(prdy), .pair_data(pd));

  dqr_src_model SRC (.clock(clock), .go(go), .i_first(ord), .i_rise(edg), .i_word(iw),
    .q_word(qw), .room(srdy), .busy(busy), .bus(bus), .dclk(dqc), .cclk(cvc));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Output is always offset binary: two's complement input has its sign bit flipped
  function automatic dqr_pkg::dqr_pair_t exp_pair(input dqr_pkg::dqr_word_t i, q,
                                                  input logic tw);
    dqr_pkg::dqr_word_t m;
    m = tw ? {1'b1, {(dqr_pkg::SAMPLE_W-1){1'b0}}} : '0;
    return '{i: i ^ m, q: q ^ m};
  endfunction : exp_pair

  task automatic chk_reg(input logic [7:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pair(input dqr_pkg::dqr_pair_t got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t pair got %h exp %h", $time, got, exp);
    end
  endtask : chk_pair

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic do_reset();
    reset = 1'b1;
    tick(3);
    reset = 1'b0;
  endtask : do_reset

  task automatic wreg(input logic [7:0] v);
    wr = 1'b1;
    wd = v;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wreg

  // Bounded wait for the searching flag to clear
  task automatic wait_lock(input int lim);
    int n;
    n = 0;
    while (rd[4] !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    chk_reg({7'h0, rd[4]}, 8'h00, "lock");
  endtask : wait_lock

  task automatic send(input dqr_pkg::dqr_word_t i, q);
    exq.push_back(exp_pair(i, q, twos));
    iw = i;
    qw = q;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(1);
    while (busy) tick(1);
  endtask : send

  task automatic drain();
    int n;
    n = 0;
    while (exq.size() != 0 && n < 300) begin
      tick(1);
      n++;
    end
    chk_reg(8'(exq.size()), 8'h00, "pairs lost");
  endtask : drain

  // Receiver stalls at random, and fully while stall is set
  always @(posedge clock) begin
    #1;
    rs   = xs(rs);
    prdy = !stall && rs[0];
  end

  // Scoreboard on the output stream
  always @(posedge clock) begin
    if (!reset && pv && prdy) begin
      if (exq.size() == 0) chk_reg(8'h01, 8'h00, "extra pair");
      else chk_pair(pd, exq.pop_front());
    end
  end

  // Hang guard
  initial begin
    tick(30000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    do_reset();
    chk_reg(rd, 8'h10, "reset value");
    wait_lock(128);
    det = rd[1:0];
    for (int c = 0; c < 4; c++) begin
      wreg(8'h04 | 8'(c));
      chk_reg(rd & 8'h07, 8'h04 | 8'(c), "forced code");
    end
    wreg(8'h03);
    chk_reg(rd & 8'h07, {6'h0, det}, "field read only");
    // Reacquire, then again mid-search: flag must outlast the first search
    wreg(8'h00);
    wreg(8'h08);
    chk_reg(rd & 8'h18, 8'h18, "reacquire");
    tick(60);
    wreg(8'h00);
    wreg(8'h08);
    tick(100);
    chk_reg({7'h0, rd[4]}, 8'h01, "restart");
    wait_lock(60);
    coe = 1'b1;
    tick(2);
    chk_reg({6'h0, doe, psm}, 8'h02, "clock out");
    strap = 1'b1;
    tick(6);
    chk_reg({6'h0, doe, psm}, 8'h01, "pin mode");
    sck = 1'b1;
    tick(6);
    chk_reg({7'h0, rd[4]}, 8'h01, "pin retrigger");
    wait_lock(130);
    sck = 1'b0;
    tick(6);
    chk_reg({6'h0, rd[1:0]}, 8'h00, "pin phase");
    strap = 1'b0;
    coe = 1'b0;
    // Four order and edge arrangements, random data with corner words
    for (int m = 0; m < 4; m++) begin
      sd = xs(sd);
      ord = m[0];
      edg = m[1];
      twos = sd[5];
      cie = (m != 2);
      do_reset();
      wait_lock(128);
      chk_reg({7'h0, dco}, {7'h0, ord ^ edg}, "clock out level");
      wreg(8'h04 | 8'(m));
      for (int k = 0; k < 10; k++) begin
        sd = xs(sd);
        send(k == 0 ? '0 : k == 1 ? '1 : sd[13:0], k == 0 ? '1 : sd[29:16]);
      end
      drain();
      stall = 1'b1;
      send(sd[13:0], sd[27:14]);
      send(sd[20:7], sd[31:18]);
      tick(20);
      chk_reg({6'h0, srdy, pv}, 8'h01, "buffer full");
      stall = 1'b0;
      drain();
    end
    end_sim();
  end
endmodule : dqr_capture_retimer_tb_top
`default_nettype wire
